// ### inc/scap_defines.vh
/*
  constants for the strap capture and observation block: register offsets,
  field positions, reset values and derived preload patterns.
  assumes inclusion by bare name from the design file.
*/
`ifndef SCAP_DEFINES_VH
`define SCAP_DEFINES_VH

// ==========================================================
// register map
`define SCAP_ADDR_W 12
`define SCAP_OFS_RAW 12'h467
`define SCAP_OFS_DEC 12'h468

// ==========================================================
// widths and reset values
`define SCAP_NSTRAP 11
`define SCAP_RAW_RST 16'h0000
`define SCAP_DEC_RST 16'h0287
`define SCAP_ZERO16 16'h0000
`define SCAP_RAW_PAD 5'h00
`define SCAP_DONE_RST 1'b0

// ==========================================================
// strap pin index within the captured raw vector
`define SCAP_S_ISOLATE 10
`define SCAP_S_RXVALID 9
`define SCAP_S_FLD 8
`define SCAP_S_MDIX_DIS 7
`define SCAP_S_SPARE 6
`define SCAP_S_LED 5
`define SCAP_S_RMII 4
`define SCAP_S_SLAVE 3
`define SCAP_S_AN1 2
`define SCAP_S_AN0 1
`define SCAP_S_AN_DIS 0

// ==========================================================
// decoded register fields
`define SCAP_D_ISOLATE 14
`define SCAP_D_RXVALID 12
`define SCAP_D_FIXED9 9
`define SCAP_D_FLD 8
`define SCAP_D_MDIX 7
`define SCAP_D_RMII 4
`define SCAP_D_SLAVE 3
`define SCAP_D_AN1 2
`define SCAP_D_AN0 1
`define SCAP_D_AN_EN 0

// ==========================================================
// fast link down preload for third control reg bits 10,3:0
`define SCAP_FLD_OFF 5'h00
`define SCAP_FLD_ON 5'h1A

// ==========================================================
// advertisement ability bits 8:5 per selector pair
`define SCAP_ADV_SEL0 4'h1
`define SCAP_ADV_SEL1 4'h3
`define SCAP_ADV_SEL2 4'h5
`define SCAP_ADV_SEL3 4'hF

`endif

// ### rtl/scap_strap_capture.v
/*
  strap capture and observation: samples the bootstrap pins once as reset
  releases and shows them in a raw register and a decoded register, plus
  the derived preload values for downstream control registers.
  assumes strap pins are static around reset, a register port on clk_i,
  and that nothing expects the two read-only registers to take writes:
  the write strobe and write data are accepted and fall away.
*/
// Notes on behaviour
// - eleven captured strap levels sit in raw bits 10:0 (1 high, 0 low), bits 15:11 read zero.
// - in basic pin mode the isolation strap (decoded bit 14) sets control isolation bit 10.
// - in rmii mode decoded bit 12 makes the receive-valid pin carry crs_dv (0) or rx_dv (1).
// - decoded bit 8 preloads fast-link-down bits 10,3:0 with 5'b00000 or 5'b11010.
// - decoded bit 7 is the inverse of the crossover disable strap and resets to 1.
// - decoded bit 4 picks mii (0) or rmii (1); bit 3 picks rmii master (0) or slave (1).
// - decoded bits 2 and 1 set advertisement bits 8:5 and both reset to 1.
// - decoded bit 0 is the inverse of the auto-negotiation disable strap and resets to 1.
`timescale 1ns/1ps
`default_nettype none
`include "scap_defines.vh"

module scap_strap_capture (
  input wire clk_i, // 100 MHz clock
  input wire rst_n_i, // synchronous reset, active low
  input wire ce_i, // clock enable, freezes state when low
  input wire [`SCAP_NSTRAP-1:0] strap_pins_i, // raw strap pin levels
  input wire basic_mode_i, // device in basic pin mode
  input wire [`SCAP_ADDR_W-1:0] addr_i, // register address
  input wire [15:0] wdata_i, // write data, ignored
  input wire wr_i, // write strobe, registers are read only
  input wire rd_i, // read strobe
  output reg [15:0] rdata_o, // read data, cycle after strobe
  output reg captured_o, // straps captured and valid
  output reg mac_isolate_o, // control isolation bit preload
  output reg rx_dv_mode_o, // receive-valid pin carries rx_dv
  output reg rmii_sel_o, // mac interface is rmii
  output reg rmii_slave_o, // rmii reference clock slave
  output reg auto_crossover_en_o, // auto mdi/mdix enabled
  output reg autoneg_enable_o, // auto-negotiation enabled
  output reg [4:0] fld_preload_o, // third control reg bits 10,3:0
  output reg [3:0] adv_ability_o // advertisement bits 8:5
);

  // ==========================================================
  // capture sequencer states
  localparam [1:0] ST_ARMED = 2'b01; // waiting for the first enabled cycle
  localparam [1:0] ST_HOLD = 2'b10; // captured, frozen until the next reset
  localparam [15:0] DEC_RST = `SCAP_DEC_RST;

  // ==========================================================
  // state and next values
  reg [1:0] state;
  reg [15:0] raw;
  reg [15:0] dec;
  reg [1:0] next_state;
  reg [15:0] next_raw;
  reg [15:0] next_dec;
  reg next_captured;
  reg next_mac_isolate;
  reg next_rx_dv_mode;
  reg next_rmii_sel;
  reg next_rmii_slave;
  reg next_auto_crossover_en;
  reg next_autoneg_enable;
  reg [4:0] next_fld_preload;
  reg [3:0] next_adv_ability;
  reg [15:0] next_rdata;
  wire [`SCAP_NSTRAP-1:0] sync2;

  // ==========================================================
  // pin synchroniser
  // straps are asynchronous to clk_i; only the second stage feeds logic
  genvar gi;
  generate
    for (gi = 0; gi < `SCAP_NSTRAP; gi = gi + 1) begin : g_sync
      reg stage1;
      reg stage2;
      always @(posedge clk_i) begin
        if (ce_i) begin
          stage1 <= strap_pins_i[gi];
          stage2 <= stage1;
        end
      end
      assign sync2[gi] = stage2;
    end
  endgenerate

  // ==========================================================
  // decode of captured levels into configuration
  // pins 6 and 5 show only in the raw register
  function [15:0] decode;
    input [`SCAP_NSTRAP-1:0] s;
    begin
      decode = `SCAP_ZERO16;
      decode[`SCAP_D_ISOLATE] = s[`SCAP_S_ISOLATE];
      decode[`SCAP_D_RXVALID] = s[`SCAP_S_RXVALID];
      decode[`SCAP_D_FIXED9] = 1'b1;
      decode[`SCAP_D_FLD] = s[`SCAP_S_FLD];
      decode[`SCAP_D_MDIX] = ~s[`SCAP_S_MDIX_DIS];
      decode[`SCAP_D_RMII] = s[`SCAP_S_RMII];
      decode[`SCAP_D_SLAVE] = s[`SCAP_S_SLAVE];
      decode[`SCAP_D_AN1] = s[`SCAP_S_AN1];
      decode[`SCAP_D_AN0] = s[`SCAP_S_AN0];
      decode[`SCAP_D_AN_EN] = ~s[`SCAP_S_AN_DIS];
    end
  endfunction

  // advertisement from the two selector bits: 00 10H, 01 10H+10F, 10 100H+10H, 11 all
  function [3:0] adv_map;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: adv_map = `SCAP_ADV_SEL0;
        2'h1: adv_map = `SCAP_ADV_SEL1;
        2'h2: adv_map = `SCAP_ADV_SEL2;
        default: adv_map = `SCAP_ADV_SEL3;
      endcase
    end
  endfunction

  // register address match, shared by both read decodes
  function addr_hit;
    input [`SCAP_ADDR_W-1:0] a;
    input [`SCAP_ADDR_W-1:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  // ==========================================================
  // one-shot capture sequencer
  // capture reads stage two, so pins must settle two cycles before release
  always @* begin
    next_state = state;
    next_raw = raw;
    next_dec = dec;
    next_captured = captured_o;
    case (state)
      ST_ARMED: begin
        next_state = ST_HOLD;
        next_raw = {`SCAP_RAW_PAD, sync2};
        next_dec = decode(sync2);
        next_captured = 1'b1;
      end
      ST_HOLD: begin
        next_state = ST_HOLD;
      end
      default: begin
        next_state = ST_ARMED;
      end
    endcase
  end

  // ce_i low freezes every flop, reset excepted
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_ARMED;
      raw <= `SCAP_RAW_RST;
      dec <= `SCAP_DEC_RST;
      captured_o <= `SCAP_DONE_RST;
    end else if (ce_i) begin
      state <= next_state;
      raw <= next_raw;
      dec <= next_dec;
      captured_o <= next_captured;
    end
  end

  // ==========================================================
  // derived configuration outputs
  // outputs lag the decoded register by one cycle
  always @* begin
    next_mac_isolate = basic_mode_i & dec[`SCAP_D_ISOLATE];
    next_rx_dv_mode = dec[`SCAP_D_RMII] & dec[`SCAP_D_RXVALID];
    next_rmii_sel = dec[`SCAP_D_RMII];
    next_rmii_slave = dec[`SCAP_D_RMII] & dec[`SCAP_D_SLAVE];
    next_auto_crossover_en = dec[`SCAP_D_MDIX];
    next_autoneg_enable = dec[`SCAP_D_AN_EN];
    next_fld_preload = dec[`SCAP_D_FLD] ? `SCAP_FLD_ON : `SCAP_FLD_OFF;
    next_adv_ability = adv_map({dec[`SCAP_D_AN1], dec[`SCAP_D_AN0]});
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      mac_isolate_o <= DEC_RST[`SCAP_D_ISOLATE];
      rx_dv_mode_o <= DEC_RST[`SCAP_D_RMII] & DEC_RST[`SCAP_D_RXVALID];
      rmii_sel_o <= DEC_RST[`SCAP_D_RMII];
      rmii_slave_o <= DEC_RST[`SCAP_D_RMII] & DEC_RST[`SCAP_D_SLAVE];
      auto_crossover_en_o <= DEC_RST[`SCAP_D_MDIX];
      autoneg_enable_o <= DEC_RST[`SCAP_D_AN_EN];
      fld_preload_o <= DEC_RST[`SCAP_D_FLD] ? `SCAP_FLD_ON : `SCAP_FLD_OFF;
      adv_ability_o <= adv_map({DEC_RST[`SCAP_D_AN1], DEC_RST[`SCAP_D_AN0]});
    end else if (ce_i) begin
      mac_isolate_o <= next_mac_isolate;
      rx_dv_mode_o <= next_rx_dv_mode;
      rmii_sel_o <= next_rmii_sel;
      rmii_slave_o <= next_rmii_slave;
      auto_crossover_en_o <= next_auto_crossover_en;
      autoneg_enable_o <= next_autoneg_enable;
      fld_preload_o <= next_fld_preload;
      adv_ability_o <= next_adv_ability;
    end
  end

  // ==========================================================
  // register read port, unmapped reads zero
  always @* begin
    next_rdata = `SCAP_ZERO16;
    if (rd_i && addr_hit(addr_i, `SCAP_OFS_RAW)) begin
      next_rdata = raw;
    end else if (rd_i && addr_hit(addr_i, `SCAP_OFS_DEC)) begin
      next_rdata = dec;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= `SCAP_ZERO16;
    end else if (ce_i) begin
      rdata_o <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ### tb/scap_strap_model.sv
/* strap resistor model: holds every strap pin at its pull level.
   assumes the levels stay put around reset. */
`timescale 1ns/1ps
`default_nettype none
module scap_strap_model (
  input wire logic [10:0] level_i, // pull levels
  output logic [10:0] pins_o // pin levels
);
  assign pins_o = level_i;
endmodule
`default_nettype wire

// ### tb/scap_strap_capture_asserts.sv
/* port checker for strap capture.
   assumes a bind onto scap_strap_capture. */
`timescale 1ns/1ps
`default_nettype none
module scap_chk (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic ce_i, // enable
  input wire logic basic_mode_i, // basic mode
  input wire logic [11:0] addr_i, // address
  input wire logic rd_i, // read
  input wire logic [15:0] rdata_o, // data
  input wire logic captured_o, // done
  input wire logic mac_isolate_o, // isolate
  input wire logic rx_dv_mode_o, // rx_dv
  input wire logic rmii_sel_o, // rmii
  input wire logic rmii_slave_o, // slave
  input wire logic auto_crossover_en_o, // mdix
  input wire logic autoneg_enable_o, // aneg
  input wire logic [4:0] fld_preload_o, // fld
  input wire logic [3:0] adv_ability_o // adv
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  raw_upper_zero_a: assert property (ce_i && rd_i && addr_i == 12'h467 |=>
    rdata_o[15:11] == 5'h00) else $error("raw upper bits set");
  idle_rdata_zero_a: assert property (ce_i && !rd_i |=> rdata_o == 16'h0000)
    else $error("read data not cleared");
  iso_gate_a: assert property (!basic_mode_i ##1 !basic_mode_i |-> !mac_isolate_o)
    else $error("isolate outside basic mode");
  rxdv_gate_a: assert property (rx_dv_mode_o |-> rmii_sel_o)
    else $error("rx_dv without rmii");
  slave_gate_a: assert property (rmii_slave_o |-> rmii_sel_o)
    else $error("slave without rmii");
  fld_pattern_a: assert property (fld_preload_o inside {5'h00, 5'h1A})
    else $error("bad fast link down pattern");
  capture_hold_a: assert property (captured_o && $past(captured_o, 2) |-> $stable({
    rmii_sel_o, rmii_slave_o, rx_dv_mode_o, auto_crossover_en_o, autoneg_enable_o,
    fld_preload_o, adv_ability_o})) else $error("capture changed");
  reset_defaults_a: assert property (disable iff (1'b0) !rst_n_i ##1 !rst_n_i |->
    auto_crossover_en_o && autoneg_enable_o && adv_ability_o == 4'hF && !captured_o)
    else $error("bad reset defaults");
  cover property (ce_i && rd_i && addr_i == 12'h468);
  cover property (rx_dv_mode_o && rmii_slave_o);
  cover property (fld_preload_o == 5'h1A);
endmodule
bind scap_strap_capture scap_chk u_scap_chk (.clk_i, .rst_n_i, .ce_i, .basic_mode_i,
  .addr_i, .rd_i, .rdata_o, .captured_o, .mac_isolate_o, .rx_dv_mode_o, .rmii_sel_o,
  .rmii_slave_o, .auto_crossover_en_o, .autoneg_enable_o, .fld_preload_o, .adv_ability_o);
`default_nettype wire

// ### tb/tb.sv
/* self-checking bench for strap capture and observation.
   assumes the strap model drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic basic_mode_i = 1'b1;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [15:0] wdata_i = 16'h0000;
  logic [10:0] level = 11'h5A5;
  wire [10:0] pins;
  wire [15:0] rdata_o;
  wire captured_o, mac_isolate_o, rx_dv_mode_o, rmii_sel_o, rmii_slave_o;
  wire auto_crossover_en_o, autoneg_enable_o;
  wire [4:0] fld_preload_o;
  wire [3:0] adv_ability_o;
  wire [15:0] derived = {1'b0, rx_dv_mode_o, rmii_slave_o, auto_crossover_en_o,
    autoneg_enable_o, fld_preload_o, adv_ability_o, rmii_sel_o, mac_isolate_o};
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [3:0] amap [4] = '{4'h1, 4'h3, 4'h5, 4'hF};
  scap_strap_model u_scap_strap_model (.level_i(level), .pins_o(pins));
  scap_strap_capture u_scap_strap_capture (.clk_i, .rst_n_i, .ce_i, .strap_pins_i(pins),
    .basic_mode_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .captured_o, .mac_isolate_o,
    .rx_dv_mode_o, .rmii_sel_o, .rmii_slave_o, .auto_crossover_en_o, .autoneg_enable_o,
    .fld_preload_o, .adv_ability_o);
  always #5 clk_i = ~clk_i;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors = errors + 1;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(what, rdata_o, exp);
  endtask
  initial begin
    logic [10:0] p;
    logic [15:0] e;
    foreach (amap[i]) begin
      case (i)
        0: p = 11'h5A5;
        1: p = 11'h25A;
        2: p = 11'h011;
        default: p = 11'h7EE;
      endcase
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      level <= p;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rdc(12'h467, {5'h00, p}, "raw");
      e = {1'b0, p[10], 1'b0, p[9], 3'h1, p[8], ~p[7], 2'h0, p[4:1], ~p[0]};
      rdc(12'h468, e, "dec");
      e = {1'b0, p[4] & p[9], p[4] & p[3], ~p[7], ~p[0], p[8] ? 5'h1A : 5'h00,
        amap[p[2:1]], p[4], p[10]};
      chk("derived", derived, e);
      @(posedge clk_i);
      wr_i <= 1'b1;
      wdata_i <= 16'hFFFF;
      level <= ~p;
      basic_mode_i <= 1'b0;
      @(posedge clk_i);
      wr_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 chk("isolate", mac_isolate_o, 16'h0000);
      @(posedge clk_i);
      basic_mode_i <= 1'b1;
      rdc(12'h467, {5'h00, p}, "held");
      rdc(12'h466, 16'h0000, "unmapped");
      $display("pattern %0d done", i);
    end
    finish_test();
  end
endmodule
`default_nettype wire
